// ==== src/sfa_align.sv ====
// SYSREF gating, edge detection and frame / multiframe counter alignment.
// Assumes core_clk is the device sampling clock and the SYSREF source keeps
// its own spacing and pulse width; offset code is applied by the analog front.
`timescale 1ns/1ps

// Operation
// - Each SYSREF rising edge is the reference for frame and multiframe phase.
// - On each edge, compare current counter phase with the edge.
// - Agreeing edge leaves counters untouched and the link running.
// - Disagreeing edge drops the link and re-phases counters to the edge.
// - Periodic SYSREF: first edge aligns, later on-time edges do nothing.
// - Gapped bursts: the first edge of a burst re-aligns only when it is off the multiframe boundary.
// - Off-spacing or mistimed edge forces re-alignment.
// - SYSREF passes an AND gate under a detection enable; disabled edges vanish.
// - A selectable DC offset code for the idle SYSREF input is exposed.
// - Enabling the gate while SYSREF is high counts as a rising edge.
module sfa_align #(
  parameter int unsigned FRAME_LEN = 1,   // Samples per frame; one keeps a multiframe at K samples.
  parameter int unsigned K_FRAMES  = 32   // Frames per multiframe.
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  // SYSREF pin and configuration
  input  wire logic                         sysref_in,
  input  wire logic                         detect_en,
  input  wire logic [1:0]                   offset_sel,
  // Alignment outputs
  output logic [1:0]                        offset_sel_q,
  output logic [sfa_pkg::FRAME_W-1:0]       frame_cnt_q,
  output logic [sfa_pkg::LMFC_W-1:0]        lmfc_cnt_q,
  output logic                              frame_tick_q,
  output logic                              lmfc_tick_q,
  output sfa_pkg::sfa_status_s              status_q
);

  localparam logic [sfa_pkg::FRAME_W-1:0] FRAME_LAST = sfa_pkg::FRAME_W'(FRAME_LEN - 1);
  localparam logic [sfa_pkg::LMFC_W-1:0]  LMFC_LAST  = sfa_pkg::LMFC_W'(K_FRAMES - 1);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic sr_s2;
  logic sr_s3;
  logic sr_lvl_q;
  logic sr_lvl_d;

  sfa_sync i_sfa_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (sysref_in),
    .stage2_q (sr_s2),
    .stage3_q (sr_s3)
  );

  // A change is accepted only once stages two and three agree.
  always_comb begin
    sr_lvl_d = (sr_s2 == sr_s3) ? sr_s3 : sr_lvl_q;
  end

  // ----------------------------------------------------------------------
  // Gate and edge detection
  // ----------------------------------------------------------------------
  logic gated;
  logic gated_q;
  logic rise;

  // The enable is ANDed with the level, so raising the enable while SYSREF
  // is high also produces a step; that false edge is accepted on purpose.
  assign gated = sr_lvl_q & detect_en;
  assign rise  = gated & ~gated_q;

  // ----------------------------------------------------------------------
  // Counters and alignment decision
  // ----------------------------------------------------------------------
  sfa_pkg::sfa_state_e           state_q;
  sfa_pkg::sfa_state_e           state_d;
  logic [sfa_pkg::FRAME_W-1:0]   frame_d;
  logic [sfa_pkg::LMFC_W-1:0]    lmfc_d;
  logic                          ftick_d;
  logic                          ltick_d;
  logic                          agree;
  sfa_pkg::sfa_status_s          status_d;

  // An edge agrees when it lands on the multiframe boundary, i.e. both
  // counters are about to wrap; any other phase is off-spacing.
  assign agree = (frame_cnt_q == FRAME_LAST) && (lmfc_cnt_q == LMFC_LAST);

  always_comb begin
    state_d  = state_q;
    frame_d  = frame_cnt_q;
    lmfc_d   = lmfc_cnt_q;
    ftick_d  = 1'b0;
    ltick_d  = 1'b0;
    status_d = status_q;
    status_d.edge_seen = rise;
    status_d.realign   = 1'b0;
    status_d.link_drop = 1'b0;
    // Free-running frame and multiframe phase.
    if (frame_cnt_q == FRAME_LAST) begin
      frame_d = sfa_pkg::FRAME_ZERO;
      ftick_d = 1'b1;
      if (lmfc_cnt_q == LMFC_LAST) begin
        lmfc_d  = sfa_pkg::LMFC_ZERO;
        ltick_d = 1'b1;
      end else begin
        lmfc_d = lmfc_cnt_q + sfa_pkg::LMFC_ONE;
      end
    end else begin
      frame_d = frame_cnt_q + sfa_pkg::FRAME_ONE;
    end
    if (rise) begin
      if ((state_q == sfa_pkg::SFA_ALIGNED) && agree) begin
        // Counters already wrap here; the link is left alone.
        status_d.aligned = 1'b1;
      end else begin
        // Edge while unaligned, or any edge off the multiframe boundary: re-phase so the
        // cycle after the edge is sample zero of a fresh multiframe.
        frame_d            = sfa_pkg::FRAME_ZERO;
        lmfc_d             = sfa_pkg::LMFC_ZERO;
        ftick_d            = 1'b1;
        ltick_d            = 1'b1;
        state_d            = sfa_pkg::SFA_ALIGNED;
        status_d.realign   = 1'b1;
        status_d.link_drop = 1'b1;
        status_d.aligned   = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sr_lvl_q     <= 1'b0;
      gated_q      <= 1'b0;
      state_q      <= sfa_pkg::SFA_UNALIGNED;
      frame_cnt_q  <= sfa_pkg::FRAME_ZERO;
      lmfc_cnt_q   <= sfa_pkg::LMFC_ZERO;
      frame_tick_q <= 1'b0;
      lmfc_tick_q  <= 1'b0;
      status_q     <= '0;
      offset_sel_q <= sfa_pkg::OFS_NONE;
    end else begin
      sr_lvl_q     <= sr_lvl_d;
      gated_q      <= gated;
      state_q      <= state_d;
      frame_cnt_q  <= frame_d;
      lmfc_cnt_q   <= lmfc_d;
      frame_tick_q <= ftick_d;
      lmfc_tick_q  <= ltick_d;
      status_q     <= status_d;
      offset_sel_q <= offset_sel;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_edge_realign: assert property (@(posedge core_clk) disable iff (!resetn)
    (rise && !(state_q == sfa_pkg::SFA_ALIGNED && agree)) |=>
      (status_q.link_drop && frame_cnt_q == sfa_pkg::FRAME_ZERO
       && lmfc_cnt_q == sfa_pkg::LMFC_ZERO))
    else $error("Mismatched edge did not re-phase counters.");

  a_agree_keep: assert property (@(posedge core_clk) disable iff (!resetn)
    (rise && state_q == sfa_pkg::SFA_ALIGNED && agree) |=>
      (!status_q.link_drop && !status_q.realign))
    else $error("Agreeing edge broke the link.");

  a_first_edge: assert property (@(posedge core_clk) disable iff (!resetn)
    (rise && state_q == sfa_pkg::SFA_UNALIGNED) |=> status_q.realign)
    else $error("First edge did not align.");

  // Watched at the status output, so a leak anywhere past the gate shows.
  a_gate_block: assert property (@(posedge core_clk) disable iff (!resetn)
    (!detect_en) |=> !status_q.edge_seen)
    else $error("Edge passed a closed gate.");

  a_gate_open_high: assert property (@(posedge core_clk) disable iff (!resetn)
    ($rose(detect_en) && sr_lvl_q && !gated_q) |=> status_q.edge_seen)
    else $error("Gate opening while high gave no edge.");

  a_edge_detect: assert property (@(posedge core_clk) disable iff (!resetn)
    ($rose(gated)) |=> status_q.edge_seen)
    else $error("Gated rise was missed.");

  a_mistimed: assert property (@(posedge core_clk) disable iff (!resetn)
    (rise && !agree) |=> (status_q.realign ##1 !status_q.realign))
    else $error("Mistimed edge did not force one re-alignment.");

  a_lmfc_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
    (!rise && frame_cnt_q == FRAME_LAST && lmfc_cnt_q == LMFC_LAST) |=>
      (lmfc_tick_q && lmfc_cnt_q == sfa_pkg::LMFC_ZERO))
    else $error("Multiframe did not wrap.");

  a_offset_pass: assert property (@(posedge core_clk) disable iff (!resetn)
    1'b1 |=> (offset_sel_q == $past(offset_sel)))
    else $error("Offset code not registered.");

  // A drop without a re-phase would leave the receiver resyncing to stale clocks.
  a_link_pair: assert property (@(posedge core_clk) disable iff (!resetn)
    status_q.link_drop == status_q.realign)
    else $error("Link drop and re-alignment disagree.");

  a_aligned_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    status_q.aligned |=> status_q.aligned)
    else $error("Alignment status was lost.");

  a_tick_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    lmfc_tick_q |-> (lmfc_cnt_q == sfa_pkg::LMFC_ZERO
      && frame_cnt_q == sfa_pkg::FRAME_ZERO))
    else $error("Multiframe tick off the zero phase.");

  // The sampled reset in the antecedent skips the edge on which reset is let go.
  a_frame_step: assert property (@(posedge core_clk) disable iff (!resetn)
    (resetn && !rise && frame_cnt_q != FRAME_LAST) |=>
      (frame_cnt_q == $past(frame_cnt_q) + sfa_pkg::FRAME_ONE))
    else $error("Frame counter stepped off its phase.");

endmodule : sfa_align

// ==== src/sfa_pkg.sv ====
// Shared types and constants for the frame and multiframe alignment block.
// Assumes one sample clock domain; SYSREF arrives asynchronously on a pin.
package sfa_pkg;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned LMFC_W        = 8;
  localparam int unsigned FRAME_W       = 4;
  localparam int unsigned SYNC_STAGES   = 3;
  localparam logic [7:0]  LMFC_ZERO     = 8'h00;
  localparam logic [3:0]  FRAME_ZERO    = 4'h0;
  localparam logic [7:0]  LMFC_ONE      = 8'h01;
  localparam logic [3:0]  FRAME_ONE     = 4'h1;

  // ----------------------------------------------------------------------
  // Input offset selection codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] OFS_NONE = 2'h0;
  localparam logic [1:0] OFS_POS  = 2'h1;
  localparam logic [1:0] OFS_NEG  = 2'h2;

  // Alignment state.
  typedef enum logic [1:0] {
    SFA_UNALIGNED = 2'b00,
    SFA_ALIGNED   = 2'b01
  } sfa_state_e;

  // Status bundle driven out of the block.
  typedef struct packed {
    logic aligned;
    logic link_drop;
    logic realign;
    logic edge_seen;
  } sfa_status_s;

endpackage : sfa_pkg

// ==== src/sfa_sync.sv ====
// Three-stage synchroniser for an asynchronous pin level.
// Assumes the caller compares only the second and third stages.
`timescale 1ns/1ps
module sfa_sync (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Asynchronous level in
  input  wire logic       async_in,
  // Stages two and three out
  output logic            stage2_q,
  output logic            stage3_q
);

  logic [2:0] sync_q;
  logic [2:0] sync_d;

  // Shift the pin through the chain; stage one feeds only stage two.
  always_comb begin
    sync_d = {sync_q[1:0], async_in};
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign stage2_q = sync_q[1];
  assign stage3_q = sync_q[2];

endmodule : sfa_sync

// ==== verif/sfa_sysref_src.sv ====
// SYSREF source model: a burst of rising edges a fixed number of cycles apart.
// Assumes launch in step with core_clk; the idle pin level is low.
`timescale 1ns/1ps
module sfa_sysref_src (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Burst request: spacing, high time and edge count
  input  wire logic       go,
  input  wire logic [7:0] period,
  input  wire logic [7:0] high,
  input  wire logic [7:0] pulses,
  // Pin and status
  output logic            sysref,
  output logic            busy
);
  logic [7:0] ph_q;
  logic [7:0] left_q;

  // Busy while the pin is high or edges remain.
  assign busy = sysref | (left_q != 8'h00);

  // Spacing and high time come from the caller and are kept exactly.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ph_q   <= 8'h00;
      left_q <= 8'h00;
      sysref <= 1'b0;
    end else if (go || (busy && ph_q == period && left_q != 8'h00)) begin
      ph_q   <= 8'h01;
      left_q <= go ? pulses - 8'h01 : left_q - 8'h01;
      sysref <= 1'b1;
    end else if (busy) begin
      ph_q   <= ph_q + 8'h01;
      sysref <= ph_q < high;
    end
  end
endmodule : sfa_sysref_src

// ==== verif/test_sfa_align.sv ====
// Testbench for frame and multiframe alignment: bursts, mistimed edges, gate, offset.
// Assumes the package, the design and the SYSREF source model are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %0t: got %0h, expected %0h", $time, got, exp); end end
module test_sfa_align;
  logic                        core_clk = 1'b0;
  logic                        resetn = 1'b0;
  logic                        detect_en = 1'b0;
  logic                        go = 1'b0;
  logic                        sysref;
  logic                        busy;
  logic [1:0]                  offset_sel = 2'h0;
  logic [1:0]                  offset_sel_q;
  logic [7:0]                  per = 8'h10, hi = 8'h08, np = 8'h01;
  logic [sfa_pkg::FRAME_W-1:0] frame_cnt_q;
  logic [sfa_pkg::LMFC_W-1:0]  lmfc_cnt_q;
  logic                        frame_tick_q, lmfc_tick_q;
  sfa_pkg::sfa_status_s        status_q;
  int                          cyc = 0, g = 0, n_edge = 0, n_re = 0;
  int                          err_count = 0, checks_done = 0;

  // Small frame and multiframe keep a multiframe at 16 cycles.
  sfa_align #(.FRAME_LEN(2), .K_FRAMES(8)) i_sfa_align (.core_clk(core_clk), .resetn(resetn),
    .sysref_in(sysref), .detect_en(detect_en), .offset_sel(offset_sel),
    .offset_sel_q(offset_sel_q), .frame_cnt_q(frame_cnt_q), .lmfc_cnt_q(lmfc_cnt_q),
    .frame_tick_q(frame_tick_q), .lmfc_tick_q(lmfc_tick_q), .status_q(status_q));
  sfa_sysref_src i_sfa_sysref_src (.core_clk(core_clk), .resetn(resetn), .go(go),
    .period(per), .high(hi), .pulses(np), .sysref(sysref), .busy(busy));

  always #50 core_clk = ~core_clk;

  task automatic results;
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Every edge lands on a multiframe start, and a drop always goes with a re-phase.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (status_q.edge_seen === 1'b1) begin
      n_edge++;
      `CHK(frame_cnt_q, sfa_pkg::FRAME_ZERO)
      `CHK(lmfc_tick_q, 1'b1)
      `CHK(lmfc_cnt_q, sfa_pkg::LMFC_ZERO)
      `CHK(frame_tick_q, 1'b1)
    end
    if (status_q.realign === 1'b1) n_re++;
    `CHK(status_q.link_drop, status_q.realign)
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  // Launch a burst at cycle t (or at once); counts are cleared while the pin is idle.
  task automatic fire(input int t, input logic [7:0] p, h, n);
    n_edge = 0;
    n_re = 0;
    do @(posedge core_clk); while (cyc < t);
    g = cyc;
    per <= p;
    hi <= h;
    np <= n;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
  endtask : fire

  // Wait out the burst and the pipeline, then compare edge and re-phase counts.
  task automatic settle(input int ne, nr);
    @(posedge core_clk);
    for (int i = 0; i < 900 && busy !== 1'b0; i++) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    `CHK(n_edge, ne)
    `CHK(n_re, nr)
  endtask : settle

  // Half duty at K of 8 stays inside the allowed band.
  task automatic t_periodic;
    detect_en <= 1'b1;
    `CHK(status_q.aligned, 1'b0)
    fire(0, 8'h10, 8'h08, 8'h04);
    settle(4, 1);
    `CHK(status_q.aligned, 1'b1)
  endtask : t_periodic

  // Bursts keep the pin quiet between them.
  task automatic t_bursts;
    fire(g + 133, 8'h20, 8'h08, 8'h03);
    settle(3, 1);
    fire(g + 128, 8'h10, 8'h08, 8'h02);
    settle(2, 0);
    fire(g + 96, 8'h11, 8'h08, 8'h03);
    settle(3, 2);
    fire(g + 135, 8'h10, 8'h06, 8'h01);
    settle(1, 1);
  endtask : t_bursts

  // A closed gate hides edges; opening it on a high pin counts as one.
  task automatic t_gate;
    int te;
    detect_en <= 1'b0;
    fire(0, 8'h10, 8'h08, 8'h03);
    settle(0, 0);
    fire(0, 8'h10, 8'hc8, 8'h01);
    repeat (20) @(posedge core_clk);
    detect_en <= 1'b1;
    te = cyc;
    settle(1, 1);
    fire(te + 227, 8'h10, 8'h08, 8'h01);
    settle(1, 1);
  endtask : t_gate

  // Each offset code reaches the analog front.
  task automatic t_offset;
    logic [1:0] codes [3] = '{sfa_pkg::OFS_NONE, sfa_pkg::OFS_POS, sfa_pkg::OFS_NEG};
    foreach (codes[i]) begin
      offset_sel <= codes[i];
      repeat (2) @(posedge core_clk);
      `CHK(offset_sel_q, codes[i])
    end
  endtask : t_offset

  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    t_periodic();
    t_bursts();
    t_gate();
    t_offset();
    results();
  end
endmodule : test_sfa_align
